// *** fpa_bus_cyc.sv ***
`default_nettype none
module fpa_bus_cyc #(
  parameter int WR_CYC = fpa_pkg::TWP_CYC,
  parameter int RD_CYC = fpa_pkg::TACC_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_wr,
  input wire logic [fpa_pkg::ADDR_W-1:0] i_addr,
  input wire logic [fpa_pkg::DATA_W-1:0] i_data,
  input wire logic [fpa_pkg::DATA_W-1:0] i_dq_in,
  output logic o_done,
  output logic [fpa_pkg::DATA_W-1:0] o_rdata,
  output fpa_pkg::fpa_pins_s o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [1:0] {FPA_PH_IDLE, FPA_PH_SETUP, FPA_PH_STROBE, FPA_PH_HOLD} fpa_phase_e;
  typedef struct packed {
    fpa_phase_e phase;
    logic wr;
    logic [7:0] cnt;
    logic done;
    logic [fpa_pkg::DATA_W-1:0] rdata;
    fpa_pkg::fpa_pins_s pins;
  } fpa_cyc_s;

  localparam fpa_cyc_s ST_RST = '{phase: FPA_PH_IDLE, wr: 1'b0, cnt: 8'h00, done: 1'b0,
    rdata: 16'h0000, pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0, addr: '0, dq_out: '0}};

  fpa_cyc_s st;
  fpa_cyc_s next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.phase)
      FPA_PH_IDLE: begin
        if (i_start) begin
          // Address and data settle before the strobe falls
          next_st.wr = i_wr;
          next_st.pins.addr = i_addr;
          next_st.pins.dq_out = i_data;
          next_st.pins.ce_n = 1'b0;
          next_st.pins.dq_oe = i_wr;
          next_st.phase = FPA_PH_SETUP;
        end
      end
      FPA_PH_SETUP: begin
        if (st.wr) begin
          next_st.pins.we_n = 1'b0; // see R21
          next_st.cnt = 8'(WR_CYC - 1);
        end else begin
          next_st.pins.oe_n = 1'b0;
          next_st.cnt = 8'(RD_CYC - 1);
        end
        next_st.phase = FPA_PH_STROBE;
      end
      FPA_PH_STROBE: begin
        if (st.cnt == 8'h00) begin
          if (!st.wr) begin
            next_st.rdata = i_dq_in;
          end
          next_st.pins.we_n = 1'b1;
          next_st.pins.oe_n = 1'b1;
          next_st.phase = FPA_PH_HOLD;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      FPA_PH_HOLD: begin
        next_st.pins.ce_n = 1'b1;
        next_st.pins.dq_oe = 1'b0;
        next_st.done = 1'b1;
        next_st.phase = FPA_PH_IDLE;
      end
      default: begin
        next_st = ST_RST;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;
  assign o_rdata = st.rdata;
  assign o_pins = st.pins;

  property p_write_legal;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !st.pins.we_n |-> !st.pins.ce_n && st.pins.oe_n && st.pins.dq_oe;
  endproperty
  a_write_legal: assert property (p_write_legal) else $error("write strobe without chip select"); // see R21

  property p_we_width;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(st.pins.we_n) |-> !st.pins.we_n [*8];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe too short"); // see R21

  property p_cycle_ends;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_start && st.phase == FPA_PH_IDLE) |-> ##[4:40] st.done;
  endproperty
  a_cycle_ends: assert property (p_cycle_ends) else $error("bus cycle did not finish");
endmodule
`default_nettype wire

// *** fpa_flash_model.sv ***
`default_nettype none
// Identification values are arbitrary
module fpa_flash_model #(
  parameter logic [15:0] ID1 = 16'h2201,
  parameter logic [15:0] ID2 = 16'h2210,
  parameter logic [15:0] ID3 = 16'h2202,
  parameter logic [7:0] FACT = 8'h9A,
  parameter bit FACT_LOCK = 1'b1
) (
  input wire logic i_rst_n,
  input wire logic i_byte_n,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [fpa_pkg::ADDR_W-1:0] i_addr,
  input wire logic [fpa_pkg::DATA_W-1:0] i_dq,
  output logic [fpa_pkg::DATA_W-1:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode = 2'h0;
  // Lock reads 1 when cleared, 0 when set
  logic guard_bit_lock = 1'b1, lock_register_bit0 = 1'b1;
  logic [1:0] step = 2'h0;
  logic exitp = 1'b0, pst = 1'b0, kind = 1'b0, bad = 1'b0, tog = 1'b0;
  int busy = 0, nbusy = 3;
  logic [7:0] vol_guard = 8'h00, nv_guard = 8'h00;
  logic [15:0] rgn [128];
  logic [15:0] rd, last = 16'h0000;
  logic [7:0] ofs, d;
  logic [22:0] u1, u2;
  assign ofs = i_byte_n ? i_addr[7:0] : i_addr[8:1];
  assign d = i_dq[7:0];
  assign u1 = {11'h000, i_byte_n ? fpa_pkg::UNLOCK1_WORD : fpa_pkg::UNLOCK1_BYTE};
  assign u2 = {11'h000, i_byte_n ? fpa_pkg::UNLOCK2_WORD : fpa_pkg::UNLOCK2_BYTE};
  initial begin
    for (int i = 0; i < 128; i++) rgn[i] = (i < 8) ? 16'h5E00 + 16'(i) : 16'hFFFF;
  end
  always_comb begin
    rd = i_addr[15:0];
    if (busy > 0) rd = {9'h000, tog, 6'h00};
    else if (pst) rd = {14'h0000, bad, kind};
    else if (mode == 2'h1) begin
      case (ofs)
        8'h01: rd = ID1;
        8'h0E: rd = ID2;
        8'h0F: rd = ID3;
        8'h02: rd = {15'h0000, vol_guard[i_addr[22:20]] | nv_guard[i_addr[22:20]]};
        8'h03: rd = {8'h00, FACT};
        default: rd = 16'hFFFF;
      endcase
    end else if (mode == 2'h2) begin
      rd = (i_addr[22:3] == '0 || !FACT_LOCK) ? rgn[i_addr[6:0]] : 16'h0000;
    end
  end
  // Released bus shows the inverse so a stale value never looks valid
  assign o_dq = (i_ce_n === 1'b0 && i_oe_n === 1'b0) ? rd : ~last;
  always @(posedge i_oe_n) begin
    if (i_ce_n === 1'b0) begin
      last <= rd;
      if (busy > 0) begin
        busy <= busy - 1;
        tog <= ~tog;
      end
    end
  end
  always @(posedge i_we_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= 2'h0;
      step <= 2'h0;
      exitp <= 1'b0;
      pst <= 1'b0;
      busy <= 0;
      guard_bit_lock <= 1'b1;
    end else if (i_ce_n === 1'b0 && i_oe_n === 1'b1) begin
      pst <= 1'b0;
      if (d == fpa_pkg::CODE_RESET) begin
        mode <= 2'h0;
        step <= 2'h0;
      end else if (exitp) begin
        exitp <= 1'b0;
        if (d == fpa_pkg::CODE_EXIT_TAIL) mode <= 2'h0;
      end else if (step == 2'h0 && d == fpa_pkg::CODE_UNLOCK1 && i_addr == u1) step <= 2'h1;
      else if (step == 2'h1 && d == fpa_pkg::CODE_UNLOCK2 && i_addr == u2) step <= 2'h2;
      else if (step == 2'h2 && i_addr == u1 && d == fpa_pkg::CODE_AUTOSEL) begin
        step <= 2'h0;
        if (mode == 2'h2) exitp <= 1'b1;
        else mode <= 2'h1;
      end else if (step == 2'h2 && i_addr == u1 && d == fpa_pkg::CODE_REGION) begin
        step <= 2'h0;
        mode <= 2'h2;
      end else if (step == 2'h2 && i_addr == u1 && d == 8'hC0) begin
        step <= 2'h0;
        mode <= 2'h3;
      end else if (mode == 2'h3 && step == 2'h0 && d == fpa_pkg::CODE_EXIT_TAIL) begin
        // Set lock freezes the nonvolatile bits
        if (guard_bit_lock) nv_guard[i_addr[22:20]] <= 1'b1;
      end else if (mode == 2'h2 && step == 2'h0) begin
        // Programming only clears bits, never sets them back
        if (lock_register_bit0) rgn[i_addr[6:0]] <= rgn[i_addr[6:0]] & i_dq;
      end else if (step == 2'h0 && (d == 8'hA0 || d == 8'h80)) begin
        busy <= nbusy;
        kind <= (d == 8'h80);
        pst <= 1'b1;
      end else begin
        step <= 2'h0;
        mode <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** fpa_host.sv ***
`default_nettype none
// Operation
// R01 - Poll bit 6 until stable, then expect 00h program or 01h erase, else abort.
// R02 - Device holds one global volatile lock freezing nonvolatile guard bits.
// R03 - With lock at 1, device accepts nonvolatile guard bit set and clear. The model only sets nv_guard bits and has no clear.
// R04 - Only hardware reset or power-up clears the global lock.
// R05 - Sector protected when either volatile or nonvolatile guard bit is set.
// R06 - Lock set allows only volatile guard bits to change.
// R07 - Device offers a 128-word security region outside the array.
// R08 - Region lock status is bit 7 of autoselect read at offset 03h.
// R09 - Indicator 0 means customer lockable, 1 means factory locked.
// R10 - Factory-locked part holds 8-word serial field at region words 0 to 7.
// R11 - Lock register bit 0 at 0 protects the region permanently.
// R12 - Host issues exit sequence after region work to restore array read.
// R13 - Security region is one-time programmable.
// R14 - One write of F0 anywhere returns the device to array read.
// R15 - Autoselect entry is AA at 555, 55 at 2AA, 90 at 555.
// R16 - Autoselect returns identification at offsets X01, X0E, X0F.
// R17 - Offset X02 at a sector address returns 00 unprotected, 01 protected.
// R18 - Offset X03 returns the factory protect indicator value.
// R19 - Unlock ending with 88 maps the security region into read space.
// R20 - Unlock ending with 90 then 00 anywhere leaves the security region.
// R21 - Write cycle only with chip select and write strobe low, output enable high.
// R22 - Device abandons invalid sequences and returns to array read.
// R23 - Device serves identification data in autoselect until reset or exit.
module fpa_host #(
  parameter int POLL_MAX = fpa_pkg::POLL_MAX
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_byte_mode,
  input wire logic i_req_valid,
  input wire fpa_pkg::fpa_req_s i_req,
  output logic o_req_ready,
  output logic o_done,
  output logic o_fail,
  output logic [fpa_pkg::DATA_W-1:0] o_rdata,
  output logic o_region_locked,
  output logic o_byte_n,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [fpa_pkg::ADDR_W-1:0] o_addr,
  output logic [fpa_pkg::DATA_W-1:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [fpa_pkg::DATA_W-1:0] i_dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [1:0] {FPA_ST_IDLE, FPA_ST_ISSUE, FPA_ST_WAIT, FPA_ST_FINISH} fpa_state_e;
  typedef struct packed {
    fpa_state_e state;
    fpa_pkg::fpa_cmd_e cmd;
    logic [fpa_pkg::ADDR_W-1:0] addr;
    logic [fpa_pkg::DATA_W-1:0] data;
    logic [2:0] step;
    logic first;
    logic prev_tog;
    logic abort;
    logic [31:0] poll_cnt;
    logic ready;
    logic done;
    logic fail;
    logic [fpa_pkg::DATA_W-1:0] rdata;
    logic region;
    logic byte_n;
    logic cyc_start;
    fpa_pkg::fpa_step_s cyc;
  } fpa_host_s;

  localparam fpa_host_s ST_RST = '{state: FPA_ST_IDLE, cmd: fpa_pkg::FPA_CMD_READ, addr: '0, data: '0,
    step: 3'h0, first: 1'b1, prev_tog: 1'b0, abort: 1'b0, poll_cnt: '0, ready: 1'b0, done: 1'b0,
    fail: 1'b0, rdata: '0, region: 1'b0, byte_n: 1'b1, cyc_start: 1'b0, cyc: '0};

  fpa_host_s st;
  fpa_host_s next_st;
  fpa_pkg::fpa_step_s cur;
  logic cyc_done;
  logic [fpa_pkg::DATA_W-1:0] cyc_rdata;
  fpa_pkg::fpa_pins_s pins;
  logic is_poll;
  logic tog_stopped;
  logic [7:0] poll_ok;

  function automatic fpa_pkg::fpa_step_s wcyc(input logic [11:0] a, input logic [7:0] d, input logic last);
    fpa_pkg::fpa_step_s s;
    s.wr = 1'b1;
    s.addr = fpa_pkg::ADDR_W'(a);
    s.data = fpa_pkg::DATA_W'(d);
    s.last = last;
    return s;
  endfunction

  // Three-cycle unlock prefix, word or byte addresses
  function automatic fpa_pkg::fpa_step_s unlock(input logic [2:0] step, input logic bm,
                                                input logic [7:0] code);
    logic [11:0] a1;
    logic [11:0] a2;
    a1 = bm ? fpa_pkg::UNLOCK1_BYTE : fpa_pkg::UNLOCK1_WORD;
    a2 = bm ? fpa_pkg::UNLOCK2_BYTE : fpa_pkg::UNLOCK2_WORD;
    case (step)
      3'h0: return wcyc(a1, fpa_pkg::CODE_UNLOCK1, 1'b0);
      3'h1: return wcyc(a2, fpa_pkg::CODE_UNLOCK2, 1'b0);
      default: return wcyc(a1, code, 1'b0);
    endcase
  endfunction

  always_comb begin
    cur = '0;
    case (st.cmd)
      fpa_pkg::FPA_CMD_RESET: cur = wcyc(12'h000, fpa_pkg::CODE_RESET, 1'b1); // see R14
      fpa_pkg::FPA_CMD_WRITE: cur = '{wr: 1'b1, addr: st.addr, data: st.data, last: 1'b1};
      fpa_pkg::FPA_CMD_AUTOSEL: begin
        if (st.step < 3'h3) begin
          cur = unlock(st.step, !st.byte_n, fpa_pkg::CODE_AUTOSEL); // see R15
        end else begin
          // Byte width doubles the offset, X03 becomes X06
          cur = '{wr: 1'b0, addr: st.byte_n ? st.addr : {st.addr[fpa_pkg::ADDR_W-2:0], 1'b0},
                  data: '0, last: 1'b1}; // see R08
        end
      end
      fpa_pkg::FPA_CMD_SEC_ENTER: begin
        cur = unlock(st.step, !st.byte_n, fpa_pkg::CODE_REGION); // see R19
        cur.last = (st.step == 3'h2);
      end
      fpa_pkg::FPA_CMD_SEC_EXIT: begin
        if (st.step < 3'h3) begin
          cur = unlock(st.step, !st.byte_n, fpa_pkg::CODE_AUTOSEL);
        end else begin
          cur = wcyc(12'h000, fpa_pkg::CODE_EXIT_TAIL, 1'b1); // see R20 see R12
        end
      end
      fpa_pkg::FPA_CMD_POLL_PROG, fpa_pkg::FPA_CMD_POLL_ERASE: begin
        cur = '{wr: 1'b0, addr: st.addr, data: '0, last: 1'b0};
      end
      default: cur = '{wr: 1'b0, addr: st.addr, data: '0, last: 1'b1};
    endcase
  end

  assign is_poll = (st.cmd == fpa_pkg::FPA_CMD_POLL_PROG) || (st.cmd == fpa_pkg::FPA_CMD_POLL_ERASE);
  assign tog_stopped = !st.first && (cyc_rdata[fpa_pkg::TOGGLE_BIT] == st.prev_tog);
  assign poll_ok = (st.cmd == fpa_pkg::FPA_CMD_POLL_ERASE) ? fpa_pkg::POLL_OK_ERASE : fpa_pkg::POLL_OK_PROG;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.cyc_start = 1'b0;
    case (st.state)
      FPA_ST_IDLE: begin
        next_st.ready = 1'b1;
        if (i_req_valid && st.ready) begin
          next_st.cmd = i_req.cmd;
          next_st.addr = i_req.addr;
          next_st.data = i_req.data;
          next_st.byte_n = !i_byte_mode;
          next_st.step = 3'h0;
          next_st.first = 1'b1;
          next_st.abort = 1'b0;
          next_st.fail = 1'b0;
          next_st.poll_cnt = '0;
          next_st.ready = 1'b0;
          next_st.state = FPA_ST_ISSUE;
        end
      end
      FPA_ST_ISSUE: begin
        next_st.cyc_start = 1'b1;
        // Failed poll leaves the device in read mode before returning
        next_st.cyc = st.abort ? wcyc(12'h000, fpa_pkg::CODE_RESET, 1'b1) : cur; // see R01
        next_st.state = FPA_ST_WAIT;
      end
      FPA_ST_WAIT: begin
        if (cyc_done) begin
          if (st.abort) begin
            next_st.state = FPA_ST_FINISH;
          end else if (is_poll) begin
            next_st.rdata = cyc_rdata;
            next_st.prev_tog = cyc_rdata[fpa_pkg::TOGGLE_BIT];
            next_st.first = 1'b0;
            next_st.poll_cnt = st.poll_cnt + 32'h0000_0001;
            if (tog_stopped) begin
              next_st.fail = (cyc_rdata[7:0] != poll_ok); // see R01
              next_st.abort = (cyc_rdata[7:0] != poll_ok);
              next_st.state = (cyc_rdata[7:0] != poll_ok) ? FPA_ST_ISSUE : FPA_ST_FINISH;
            end else if (st.poll_cnt == 32'(POLL_MAX - 1)) begin
              // Stuck toggling counts as failure too
              next_st.fail = 1'b1;
              next_st.abort = 1'b1;
              next_st.state = FPA_ST_ISSUE;
            end else begin
              next_st.state = FPA_ST_ISSUE;
            end
          end else if (!st.cyc.last) begin
            next_st.step = st.step + 3'h1;
            next_st.state = FPA_ST_ISSUE;
          end else begin
            if (!st.cyc.wr) begin
              next_st.rdata = cyc_rdata;
            end
            if (st.cmd == fpa_pkg::FPA_CMD_AUTOSEL && st.addr[7:0] == fpa_pkg::OFS_FACTORY) begin
              next_st.region = cyc_rdata[fpa_pkg::REGION_BIT]; // see R08
            end
            next_st.state = FPA_ST_FINISH;
          end
        end
      end
      FPA_ST_FINISH: begin
        next_st.done = 1'b1;
        next_st.state = FPA_ST_IDLE;
      end
      default: next_st = ST_RST;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  fpa_bus_cyc u_cyc (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_start(st.cyc_start),
    .i_wr(st.cyc.wr),
    .i_addr(st.cyc.addr),
    .i_data(st.cyc.data),
    .i_dq_in(i_dq_in),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_pins(pins)
  );

  assign o_req_ready = st.ready;
  assign o_done = st.done;
  assign o_fail = st.fail;
  assign o_rdata = st.rdata;
  assign o_region_locked = st.region;
  assign o_byte_n = st.byte_n;
  assign o_ce_n = pins.ce_n;
  assign o_we_n = pins.we_n;
  assign o_oe_n = pins.oe_n;
  assign o_addr = pins.addr;
  assign o_dq_out = pins.dq_out;
  assign o_dq_oe = pins.dq_oe;

  property p_reset_code;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.cyc_start && st.cmd == fpa_pkg::FPA_CMD_RESET) |-> st.cyc.wr && st.cyc.data[7:0] == 8'hF0;
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("reset command lacks F0 write"); // see R14

  property p_unlock_first;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.cyc_start && st.step == 3'h0 && !st.abort && (st.cmd == fpa_pkg::FPA_CMD_AUTOSEL ||
      st.cmd == fpa_pkg::FPA_CMD_SEC_ENTER || st.cmd == fpa_pkg::FPA_CMD_SEC_EXIT))
      |-> st.cyc.wr && st.cyc.data[7:0] == 8'hAA &&
          st.cyc.addr[11:0] == (st.byte_n ? 12'h555 : 12'hAAA);
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("unlock cycle one wrong"); // see R15

  property p_region_enter;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.cyc_start && st.cmd == fpa_pkg::FPA_CMD_SEC_ENTER && st.step == 3'h2)
      |-> st.cyc.wr && st.cyc.last && st.cyc.data[7:0] == 8'h88;
  endproperty
  a_region_enter: assert property (p_region_enter) else $error("region entry code wrong"); // see R19

  property p_region_exit;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.cyc_start && st.cmd == fpa_pkg::FPA_CMD_SEC_EXIT && st.step == 3'h3)
      |-> st.cyc.wr && st.cyc.data[7:0] == 8'h00 && $past(st.cyc.data[7:0], 6) != 8'hAA;
  endproperty
  a_region_exit: assert property (p_region_exit) else $error("region exit tail wrong"); // see R20

  property p_poll_result;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.done && is_poll && !o_fail)
      |-> o_rdata[7:0] == (st.cmd == fpa_pkg::FPA_CMD_POLL_ERASE ? 8'h01 : 8'h00);
  endproperty
  a_poll_result: assert property (p_poll_result) else $error("poll passed with bad status"); // see R01

  property p_poll_abort;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    ($rose(st.abort)) |-> ##[1:40] (st.cyc_start && st.cyc.data[7:0] == 8'hF0);
  endproperty
  a_poll_abort: assert property (p_poll_abort) else $error("failed poll not followed by reset"); // see R01

  property p_region_bit;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st.done && st.cmd == fpa_pkg::FPA_CMD_AUTOSEL && st.addr[7:0] == 8'h03)
      |-> o_region_locked == o_rdata[7];
  endproperty
  a_region_bit: assert property (p_region_bit) else $error("region indicator not from bit 7"); // see R08

  property p_done_pulse;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    st.done |=> !st.done && st.ready;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse"); // see R12
endmodule
`default_nettype wire

// *** fpa_pkg.sv ***
`default_nettype none
package fpa_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  // Unlock addresses, word and byte width
  localparam logic [11:0] UNLOCK1_WORD = 12'h555;
  localparam logic [11:0] UNLOCK2_WORD = 12'h2AA;
  localparam logic [11:0] UNLOCK1_BYTE = 12'hAAA;
  localparam logic [11:0] UNLOCK2_BYTE = 12'h555;
  // Command data codes
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_AUTOSEL = 8'h90;
  localparam logic [7:0] CODE_REGION = 8'h88;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_EXIT_TAIL = 8'h00;
  // Status decode
  localparam logic [7:0] OFS_FACTORY = 8'h03;
  localparam int TOGGLE_BIT = 6;
  localparam int REGION_BIT = 7;
  localparam logic [7:0] POLL_OK_PROG = 8'h00;
  localparam logic [7:0] POLL_OK_ERASE = 8'h01;
  // Bus timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TWP_NS = 35;
  localparam int TACC_NS = 70;
  localparam int TWP_CYC = (TWP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TACC_CYC = (TACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_MAX = 65536;

  typedef enum logic [2:0] {
    FPA_CMD_READ, FPA_CMD_RESET, FPA_CMD_AUTOSEL, FPA_CMD_SEC_ENTER,
    FPA_CMD_SEC_EXIT, FPA_CMD_WRITE, FPA_CMD_POLL_PROG, FPA_CMD_POLL_ERASE
  } fpa_cmd_e;

  typedef struct packed {
    fpa_cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpa_req_s;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
  } fpa_pins_s;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic last;
  } fpa_step_s;
endpackage
`default_nettype wire

// *** tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ID1 = 16'h2201;
  localparam logic [15:0] ID2 = 16'h2210;
  localparam logic [15:0] ID3 = 16'h2202;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_byte_mode = 1'b0;
  logic i_req_valid = 1'b0;
  fpa_pkg::fpa_req_s i_req = '0;
  logic o_req_ready, o_done, o_fail, o_region_locked, o_byte_n, o_ce_n, o_we_n, o_oe_n, o_dq_oe;
  logic [15:0] o_rdata, o_dq_out, i_dq_in;
  logic [22:0] o_addr;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  fpa_host #(.POLL_MAX(8)) i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_byte_mode(i_byte_mode),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done), .o_fail(o_fail),
    .o_rdata(o_rdata), .o_region_locked(o_region_locked), .o_byte_n(o_byte_n), .o_ce_n(o_ce_n),
    .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
    .i_dq_in(i_dq_in));
  fpa_flash_model #(.ID1(ID1), .ID2(ID2), .ID3(ID3)) i_flash (.i_rst_n(i_rst_n), .i_byte_n(o_byte_n),
    .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_addr(o_addr), .i_dq(o_dq_out), .o_dq(i_dq_in));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Inputs move 1 ns after the edge so the design never samples them mid-change
  task automatic req(input fpa_pkg::fpa_cmd_e c, input logic [22:0] a, input logic [15:0] dt);
    int n;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 100) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    i_req = '{cmd: c, addr: a, data: dt};
    i_req_valid = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_req_valid = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 3000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check("done", {15'h0000, o_done}, 16'h0001);
    check("ce_n", {15'h0000, o_ce_n}, 16'h0001);
    check("dq_oe", {15'h0000, o_dq_oe}, 16'h0000);
  endtask
  task automatic guard(input logic [2:0] s, input logic [15:0] exp);
    req(fpa_pkg::FPA_CMD_WRITE, {11'h000, fpa_pkg::UNLOCK1_WORD}, 16'h00AA);
    req(fpa_pkg::FPA_CMD_WRITE, {11'h000, fpa_pkg::UNLOCK2_WORD}, 16'h0055);
    req(fpa_pkg::FPA_CMD_WRITE, {11'h000, fpa_pkg::UNLOCK1_WORD}, 16'h00C0);
    req(fpa_pkg::FPA_CMD_WRITE, {s, 20'h0_0000}, 16'h0000);
    req(fpa_pkg::FPA_CMD_RESET, '0, '0);
    req(fpa_pkg::FPA_CMD_AUTOSEL, {s, 20'h0_0002}, '0);
    check("guard", o_rdata, exp);
  endtask
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      $display("Error cycle_limit expected 0 seen %0d", cycles);
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    for (int b = 0; b < 2; b++) begin
      i_byte_mode = b[0];
      req(fpa_pkg::FPA_CMD_AUTOSEL, 23'h00_0001, '0);
      check("id1", o_rdata, ID1);
      req(fpa_pkg::FPA_CMD_AUTOSEL, 23'h00_000E, '0);
      check("id2", o_rdata, ID2);
      req(fpa_pkg::FPA_CMD_AUTOSEL, 23'h00_000F, '0);
      check("id3", o_rdata, ID3);
      req(fpa_pkg::FPA_CMD_AUTOSEL, 23'h00_0003, '0);
      check("factory", o_rdata, 16'h009A);
      check("region_lock", {15'h0000, o_region_locked}, 16'h0001);
      req(fpa_pkg::FPA_CMD_READ, b[0] ? 23'h00_0002 : 23'h00_0001, '0);
      check("stay_autosel", o_rdata, ID1);
      req(fpa_pkg::FPA_CMD_RESET, '0, '0);
      req(fpa_pkg::FPA_CMD_READ, 23'h00_0123, '0);
      check("array", o_rdata, 16'h0123);
      check("byte_pin", {15'h0000, o_byte_n}, {15'h0000, ~b[0]});
    end
    $display("test ids done");
    i_byte_mode = 1'b0;
    i_flash.vol_guard = 8'h02;
    i_flash.nv_guard = 8'h04;
    for (int s = 0; s < 4; s++) begin
      req(fpa_pkg::FPA_CMD_AUTOSEL, {s[2:0], 20'h0_0002}, '0);
      check("sector", o_rdata, (s == 1 || s == 2) ? 16'h0001 : 16'h0000);
    end
    guard(3'h3, 16'h0001);
    // Lock set command is not modelled, so the bench sets the lock
    i_flash.guard_bit_lock = 1'b0;
    guard(3'h0, 16'h0000);
    req(fpa_pkg::FPA_CMD_WRITE, {11'h000, fpa_pkg::UNLOCK1_WORD}, 16'h00AA);
    req(fpa_pkg::FPA_CMD_WRITE, {11'h000, fpa_pkg::UNLOCK2_WORD}, 16'h0055);
    req(fpa_pkg::FPA_CMD_WRITE, {11'h000, fpa_pkg::UNLOCK1_WORD}, 16'h0077);
    req(fpa_pkg::FPA_CMD_READ, 23'h00_0001, '0);
    check("abandon", o_rdata, 16'h0001);
    $display("test protect done");
    req(fpa_pkg::FPA_CMD_SEC_ENTER, '0, '0);
    for (int w = 0; w < 9; w++) begin
      req(fpa_pkg::FPA_CMD_READ, 23'(w), '0);
      check("region", o_rdata, (w < 8) ? 16'h5E00 + 16'(w) : 16'h0000);
    end
    req(fpa_pkg::FPA_CMD_WRITE, 23'h00_0003, 16'h0F0F);
    req(fpa_pkg::FPA_CMD_WRITE, 23'h00_0003, 16'hFFFF);
    i_flash.lock_register_bit0 = 1'b0;
    req(fpa_pkg::FPA_CMD_WRITE, 23'h00_0003, 16'h0000);
    req(fpa_pkg::FPA_CMD_READ, 23'h00_0003, '0);
    check("otp", o_rdata, 16'h0E03);
    req(fpa_pkg::FPA_CMD_SEC_EXIT, '0, '0);
    req(fpa_pkg::FPA_CMD_READ, 23'h00_0005, '0);
    check("exit", o_rdata, 16'h0005);
    $display("test region done");
    for (int p = 0; p < 4; p++) begin
      i_flash.bad = (p == 2);
      i_flash.nbusy = (p == 3) ? 50 : 3;
      req(fpa_pkg::FPA_CMD_WRITE, '0, (p == 1) ? 16'h0080 : 16'h00A0);
      req((p == 1) ? fpa_pkg::FPA_CMD_POLL_ERASE : fpa_pkg::FPA_CMD_POLL_PROG, '0, '0);
      check("poll_fail", {15'h0000, o_fail}, {15'h0000, p >= 2});
      if (p < 2) check("poll_status", o_rdata, 16'(p));
    end
    $display("test poll done");
    req(fpa_pkg::FPA_CMD_SEC_ENTER, '0, '0);
    i_rst_n = 1'b0;
    @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    req(fpa_pkg::FPA_CMD_READ, 23'h00_0007, '0);
    check("hw_reset", o_rdata, 16'h0007);
    guard(3'h0, 16'h0001);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
